// >>> verilog/msd_defines.svh
// Purpose: Constants of the absolute short move decoder
// Assumes: Included by its bare name
// Notes:   Opcode field positions are bit numbers of the 32-bit opcode word; status fields are bits of the source word
`ifndef MSD_DEFINES_SVH
`define MSD_DEFINES_SVH

// Opcode prefix and field positions
`define MSD_OP_PREFIX     12'h007
`define MSD_OP_MSB        31
`define MSD_OP_LSB        20
`define MSD_EA_MSB        19
`define MSD_EA_LSB        14
`define MSD_REG_MSB       19
`define MSD_REG_LSB       13
`define MSD_DISP_ZERO_MSB 19
`define MSD_DISP_ZERO_LSB 17
`define MSD_SEL_MSB       13
`define MSD_SEL_LSB       12
`define MSD_B11           11
`define MSD_ES_BIT        10
`define MSD_SS_BIT        9
`define MSD_W_BIT         8
`define MSD_SHORT_GUARD   7
`define MSD_SHORT_MSB     6
`define MSD_SHORT_LSB     0

// Status word source fields
`define MSD_CC_MSB        7
`define MSD_CC_LSB        0
`define MSD_EXC_MSB       15
`define MSD_EXC_LSB       8
`define MSD_TRAP_MSB      20
`define MSD_TRAP_LSB      16
`define MSD_STATUS_RST    21'h000000

// Register and mode codes
`define MSD_CODE_STATUS   7'h79
`define MSD_EA_EXT_MODE   3'h6
`define MSD_EA_ABS        6'h30
`define MSD_EA_IMM        6'h34
`define MSD_ONE_WORD      2'h1
`define MSD_TWO_WORDS     2'h2

`endif

// >>> verilog/msd_pkg.sv
// Purpose: Types of the absolute short move decoder
// Assumes: Nothing is imported; users write msd_pkg::name
// Notes:   Status struct packs so bit 0 is the carry flag
package msd_pkg;

    typedef enum logic [2:0] {
        MSD_FORM_BAD    = 3'b000,
        MSD_FORM_SINGLE = 3'b001,
        MSD_FORM_DOUBLE = 3'b010,
        MSD_FORM_DISP   = 3'b011,
        MSD_FORM_PMEM   = 3'b100,
        MSD_FORM_MEMMEM = 3'b101
    } msd_form_t;

    typedef enum logic [1:0] {
        MSD_SPACE_X = 2'b00,
        MSD_SPACE_Y = 2'b01,
        MSD_SPACE_P = 2'b10
    } msd_space_t;

    typedef enum logic [2:0] {
        MSD_ST_IDLE   = 3'b000,
        MSD_ST_EXT    = 3'b001,
        MSD_ST_READ   = 3'b010,
        MSD_ST_READ2  = 3'b011,
        MSD_ST_WRITE  = 3'b100,
        MSD_ST_WRITE2 = 3'b101
    } msd_state_t;

    typedef struct packed {
        logic accept;
        logic rounding;
        logic loop_flag;
        logic integer_mode;
        logic negative;
        logic zero;
        logic cc_overflow;
        logic carry;
    } msd_cond_t;

    typedef struct packed {
        logic unordered_flag;
        logic not_a_number_flag;
        logic signalling_nonnumber_flag;
        logic operand_error_flag;
        logic overflow_flag;
        logic underflow_flag;
        logic divide_by_zero_flag;
        logic inexact_flag;
    } msd_exc_t;

    typedef struct packed {
        logic invalid_op_enable;
        logic overflow_enable;
        logic underflow_enable;
        logic div_zero_enable;
        logic inexact_enable;
    } msd_trap_t;

    typedef struct packed {
        msd_trap_t trap_enable_flags;
        msd_exc_t  exception_status;
        msd_cond_t cond;
    } msd_status_t;

    typedef struct packed {
        logic       legal;
        msd_form_t  form;
        logic [5:0] ea_field;
        logic       ea_is_p;
        logic       ea_space;
        logic       short_space;
        logic       write_short;
        logic [6:0] reg_code;
        logic [6:0] short_addr;
        logic       needs_ext;
        logic       is_imm;
        logic       is_abs;
    } msd_dec_t;

endpackage

// >>> verilog/msd_decode.sv
// Purpose: Field decoder for the absolute short move opcode
// Assumes: Purely combinational; word is stable while it is looked at
// Notes:   Anything outside the known forms decodes as not legal
`timescale 1ns/10ps
`include "msd_defines.svh"

module msd_decode
(
    // Opcode
    input  wire logic [31:0]       instr_word,
    // Decoded fields
    output msd_pkg::msd_dec_t      dec
);

    function automatic logic single_code_ok(input logic [6:0] code);
        logic ok;
        ok = 1'b0;
        if (code[6:5] == 2'b00)
            ok = 1'b1; // RULE13
        else if (code[6:3] == 4'h4)
            ok = 1'b1; // RULE13
        else if (code[6:3] == 4'h5 || code[6:3] == 4'h6 || code[6:3] == 4'h7)
            ok = 1'b1; // RULE13
        else if (code[6:3] == 4'hf)
            ok = (code[2:0] != 3'h0); // RULE13
        return ok;
    endfunction

    function automatic logic double_code_ok(input logic [6:0] code);
        return (code[6:4] == 3'b101) || (code[6:2] == 5'b10001); // RULE16
    endfunction

    always_comb
    begin
        logic [5:0] ea;
        logic       ea_ok;
        ea    = instr_word[`MSD_EA_MSB:`MSD_EA_LSB];
        ea_ok = 1'b1;
        dec             = '0;
        dec.form        = msd_pkg::MSD_FORM_BAD;
        dec.ea_field    = ea;
        dec.ea_space    = instr_word[`MSD_ES_BIT];
        dec.short_space = instr_word[`MSD_SS_BIT]; // RULE7
        dec.write_short = instr_word[`MSD_W_BIT]; // RULE7
        dec.reg_code    = instr_word[`MSD_REG_MSB:`MSD_REG_LSB];
        dec.short_addr  = instr_word[`MSD_SHORT_MSB:`MSD_SHORT_LSB]; // RULE5
        if (instr_word[`MSD_SEL_MSB:`MSD_SEL_LSB] == 2'b11 && instr_word[`MSD_B11])
            dec.form = msd_pkg::MSD_FORM_MEMMEM; // RULE17
        else if (instr_word[`MSD_SEL_MSB:`MSD_SEL_LSB] == 2'b11
                 && instr_word[`MSD_B11:`MSD_ES_BIT] == 2'b01)
            dec.form = msd_pkg::MSD_FORM_PMEM; // RULE11
        else if (instr_word[`MSD_SEL_MSB:`MSD_SEL_LSB] == 2'b10 && instr_word[`MSD_B11]
                 && instr_word[`MSD_DISP_ZERO_MSB:`MSD_DISP_ZERO_LSB] == 3'h0)
            dec.form = msd_pkg::MSD_FORM_DISP; // RULE10
        else if (!instr_word[`MSD_SEL_LSB] && instr_word[`MSD_B11:`MSD_ES_BIT] == 2'b00)
            dec.form = msd_pkg::MSD_FORM_SINGLE; // RULE12
        else if (instr_word[`MSD_SEL_LSB] && instr_word[`MSD_B11:`MSD_SS_BIT] == 3'h0)
            dec.form = msd_pkg::MSD_FORM_DOUBLE; // RULE16
        dec.ea_is_p = (dec.form == msd_pkg::MSD_FORM_PMEM);
        // Only memory-backed forms carry a mode field worth checking
        if (dec.form == msd_pkg::MSD_FORM_MEMMEM || dec.form == msd_pkg::MSD_FORM_PMEM)
        begin
            dec.needs_ext = (ea[5:3] == `MSD_EA_EXT_MODE);
            dec.is_abs    = (ea == `MSD_EA_ABS); // RULE9
            dec.is_imm    = (ea == `MSD_EA_IMM);
            if (dec.needs_ext && !dec.is_abs && !dec.is_imm)
                ea_ok = 1'b0; // RULE8
            // Immediate is never alterable and never a destination
            if (dec.is_imm && (dec.ea_is_p || !dec.write_short))
                ea_ok = 1'b0; // RULE8
        end
        if (dec.form == msd_pkg::MSD_FORM_DISP)
            dec.needs_ext = 1'b1; // RULE10
        dec.legal = (instr_word[`MSD_OP_MSB:`MSD_OP_LSB] == `MSD_OP_PREFIX)
                    && !instr_word[`MSD_SHORT_GUARD]
                    && (dec.form != msd_pkg::MSD_FORM_BAD) && ea_ok;
        if (dec.form == msd_pkg::MSD_FORM_SINGLE && !single_code_ok(dec.reg_code))
            dec.legal = 1'b0;
        if (dec.form == msd_pkg::MSD_FORM_DOUBLE && !double_code_ok(dec.reg_code))
            dec.legal = 1'b0;
    end

endmodule

// >>> verilog/msd_short_move.sv
// Purpose: Decode and execute the move-absolute-short instruction
// Assumes: Register file and address unit answer combinationally
// Notes:   One instruction at a time; memory may stall via mem_ack
//
// What this block does
// RULE1: Status word destination loads eight condition flags from source bits 0..7.
// RULE2: Status word destination loads eight exception bits from source bits 8..15.
// RULE3: Status word destination loads five trap enables from source bits 16..20.
// RULE4: Other destinations leave all flags, exceptions and trap enables unchanged.
// RULE5: Short address comes from the seven lowest opcode bits.
// RULE6: Short address is zero-extended, reaching only the lowest 128 words.
// RULE7: Space bits pick X on 0, Y on 1; W=1 writes the short word.
// RULE8: Program space needs alterable memory modes; X or Y need memory modes.
// RULE9: Absolute and displacement extension words are full 32-bit values.
// RULE10: Displacement form: 000 plus register, 10 at bits 13:12, long displacement.
// RULE11: Program form: mode field, 11 at bits 13:12, then 01SW.
// RULE12: Single register form: seven-bit code to bit 13, zero at 12, 00SW.
// RULE13: Register codes pick data parts, address, offset, modifier and control registers.
// RULE14: Execution takes two cycles plus memory access stalls; only single register moves do, each further access or extension word adds one.
// RULE15: Length is one word plus any extension word.
// RULE16: Double register form: pair code, zero space bits, separate pair coding.
// RULE17: Memory-to-memory form: mode field, 11 at 13:12, space and direction bits.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "msd_defines.svh"

module msd_short_move
#(
    parameter int DATA_W = 32
)
(
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    // Instruction word
    input  wire logic                  instr_valid,
    input  wire logic [31:0]           instr_word,
    output logic                       instr_ready,
    // Extension word
    input  wire logic                  ext_valid,
    input  wire logic [DATA_W-1:0]     ext_word,
    output logic                       ext_ready,
    // Address unit
    output logic                       agu_req,
    output logic [5:0]                 agu_mode_reg,
    output logic                       agu_disp,
    output logic [DATA_W-1:0]          agu_ext,
    input  wire logic [DATA_W-1:0]     agu_addr,
    // Memory
    output logic                       mem_req,
    output logic                       mem_we,
    output msd_pkg::msd_space_t        mem_space,
    output logic [DATA_W-1:0]          mem_addr,
    output logic [DATA_W-1:0]          mem_wdata,
    input  wire logic                  mem_ack,
    input  wire logic [DATA_W-1:0]     mem_rdata,
    // Register file
    output logic [6:0]                 reg_rd_code,
    input  wire logic [2*DATA_W-1:0]   reg_rdata,
    output logic                       reg_wr,
    output logic                       reg_wr_double,
    output logic [6:0]                 reg_wr_code,
    output logic [2*DATA_W-1:0]        reg_wdata,
    // Status and completion
    output msd_pkg::msd_status_t       status_word,
    output logic                       done,
    output logic                       illegal,
    output logic [1:0]                 instr_words
);

    msd_pkg::msd_state_t  state;
    msd_pkg::msd_state_t  next_state;
    msd_pkg::msd_dec_t    dec;
    msd_pkg::msd_dec_t    dec_q;
    msd_pkg::msd_dec_t    cur;
    msd_pkg::msd_space_t  src_space;
    msd_pkg::msd_space_t  dst_space;
    logic [DATA_W-1:0]    src_addr;
    logic [DATA_W-1:0]    dst_addr;
    logic [DATA_W-1:0]    data_hi;
    logic [DATA_W-1:0]    data_lo;
    logic [DATA_W-1:0]    short_full;
    logic [DATA_W-1:0]    ea_addr;
    logic [DATA_W-1:0]    reg_value;
    logic                 is_double;
    logic                 dst_reg;
    logic                 launch;
    logic                 finish;
    logic                 load_reg;
    logic                 load_status;
    logic                 mem_form;

    msd_decode u_decode
    (
        .instr_word (instr_word),
        .dec        (dec)
    );

    function automatic msd_pkg::msd_space_t space_of(input logic sel);
        return sel ? msd_pkg::MSD_SPACE_Y : msd_pkg::MSD_SPACE_X; // RULE7
    endfunction

    // Decode from the live word while idle, from the held copy afterwards
    assign cur         = (state == msd_pkg::MSD_ST_IDLE) ? dec : dec_q;
    assign instr_ready = (state == msd_pkg::MSD_ST_IDLE);
    assign ext_ready   = (state == msd_pkg::MSD_ST_EXT);
    assign mem_form    = (cur.form == msd_pkg::MSD_FORM_MEMMEM)
                         || (cur.form == msd_pkg::MSD_FORM_PMEM)
                         || (cur.form == msd_pkg::MSD_FORM_DISP);

    // Start of the first access, right after the last opcode word
    assign launch = ((state == msd_pkg::MSD_ST_IDLE) && instr_valid && dec.legal
                     && !dec.needs_ext)
                    || ((state == msd_pkg::MSD_ST_EXT) && ext_valid);

    assign short_full   = {{(DATA_W-7){1'b0}}, cur.short_addr}; // RULE6
    assign agu_req      = launch && mem_form && !cur.is_abs && !cur.is_imm;
    assign agu_mode_reg = cur.ea_field;
    assign agu_disp     = (cur.form == msd_pkg::MSD_FORM_DISP);
    assign agu_ext      = ext_word; // RULE9
    assign ea_addr      = cur.is_abs ? ext_word : agu_addr; // RULE9

    // The status word lives here, so it is served to moves that read it
    assign reg_rd_code = cur.reg_code;
    assign reg_value   = (cur.reg_code == `MSD_CODE_STATUS)
                         ? DATA_W'(status_word) : reg_rdata[DATA_W-1:0];

    assign mem_req   = (state == msd_pkg::MSD_ST_READ) || (state == msd_pkg::MSD_ST_READ2)
                       || (state == msd_pkg::MSD_ST_WRITE) || (state == msd_pkg::MSD_ST_WRITE2);
    assign mem_we    = (state == msd_pkg::MSD_ST_WRITE) || (state == msd_pkg::MSD_ST_WRITE2);
    assign mem_addr  = mem_we ? dst_addr : src_addr;
    assign mem_wdata = ((state == msd_pkg::MSD_ST_WRITE) && is_double) ? data_hi : data_lo;

    always_comb
    begin
        mem_space = mem_we ? dst_space : src_space;
        if (state == msd_pkg::MSD_ST_READ2 || state == msd_pkg::MSD_ST_WRITE2)
            mem_space = msd_pkg::MSD_SPACE_Y;
    end

    // Register results land in the cycle of the last read acknowledge
    assign load_reg = dst_reg && mem_ack
                      && (((state == msd_pkg::MSD_ST_READ) && !is_double)
                          || (state == msd_pkg::MSD_ST_READ2));
    assign load_status   = load_reg && !is_double && (dec_q.reg_code == `MSD_CODE_STATUS);
    assign reg_wr        = load_reg && !load_status;
    assign reg_wr_double = is_double;
    assign reg_wr_code   = dec_q.reg_code;
    assign reg_wdata     = is_double ? {data_hi, mem_rdata}
                                     : {{DATA_W{1'b0}}, mem_rdata};

    always_comb
    begin
        next_state = state;
        finish     = 1'b0;
        case (state)
            msd_pkg::MSD_ST_IDLE, msd_pkg::MSD_ST_EXT:
            begin
                if (state == msd_pkg::MSD_ST_IDLE && instr_valid && dec.legal && dec.needs_ext)
                    next_state = msd_pkg::MSD_ST_EXT; // RULE15
                else if (launch)
                begin
                    if (cur.form == msd_pkg::MSD_FORM_SINGLE
                        || cur.form == msd_pkg::MSD_FORM_DOUBLE)
                        next_state = cur.write_short ? msd_pkg::MSD_ST_WRITE
                                                     : msd_pkg::MSD_ST_READ;
                    else if (cur.is_imm)
                        next_state = msd_pkg::MSD_ST_WRITE;
                    else
                        next_state = msd_pkg::MSD_ST_READ;
                end
            end
            msd_pkg::MSD_ST_READ:
            begin
                if (mem_ack)
                begin
                    if (is_double)
                        next_state = msd_pkg::MSD_ST_READ2;
                    else if (dst_reg)
                    begin
                        next_state = msd_pkg::MSD_ST_IDLE;
                        finish     = 1'b1; // RULE14
                    end
                    else
                        next_state = msd_pkg::MSD_ST_WRITE;
                end
            end
            msd_pkg::MSD_ST_WRITE:
            begin
                if (mem_ack)
                begin
                    next_state = is_double ? msd_pkg::MSD_ST_WRITE2 : msd_pkg::MSD_ST_IDLE;
                    finish     = !is_double; // RULE14
                end
            end
            msd_pkg::MSD_ST_READ2, msd_pkg::MSD_ST_WRITE2:
            begin
                if (mem_ack)
                begin
                    next_state = msd_pkg::MSD_ST_IDLE;
                    finish     = 1'b1; // RULE14
                end
            end
            default:
            begin
                next_state = msd_pkg::MSD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            state <= msd_pkg::MSD_ST_IDLE;
        else
            state <= next_state;
    end

    // Opcode copy kept for the extension wait and the accesses
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            dec_q       <= '0;
            instr_words <= `MSD_ONE_WORD;
        end
        else if (instr_ready && instr_valid && dec.legal)
        begin
            dec_q       <= dec;
            instr_words <= dec.needs_ext ? `MSD_TWO_WORDS : `MSD_ONE_WORD; // RULE15
        end
    end

    // Source and destination set up once the address is known
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            src_space <= msd_pkg::MSD_SPACE_X;
            dst_space <= msd_pkg::MSD_SPACE_X;
            src_addr  <= '0;
            dst_addr  <= '0;
            is_double <= 1'b0;
            dst_reg   <= 1'b0;
        end
        else if (launch)
        begin
            is_double <= (cur.form == msd_pkg::MSD_FORM_DOUBLE);
            dst_reg   <= !mem_form && !cur.write_short;
            if (!mem_form)
            begin
                src_space <= (cur.form == msd_pkg::MSD_FORM_DOUBLE)
                             ? msd_pkg::MSD_SPACE_X : space_of(cur.short_space); // RULE16
                dst_space <= (cur.form == msd_pkg::MSD_FORM_DOUBLE)
                             ? msd_pkg::MSD_SPACE_X : space_of(cur.short_space); // RULE16
                src_addr  <= short_full;
                dst_addr  <= short_full;
            end
            else if (cur.write_short)
            begin
                src_space <= cur.ea_is_p ? msd_pkg::MSD_SPACE_P : space_of(cur.ea_space);
                src_addr  <= ea_addr;
                dst_space <= space_of(cur.short_space); // RULE7
                dst_addr  <= short_full;
            end
            else
            begin
                src_space <= space_of(cur.short_space); // RULE7
                src_addr  <= short_full;
                dst_space <= cur.ea_is_p ? msd_pkg::MSD_SPACE_P : space_of(cur.ea_space);
                dst_addr  <= ea_addr;
            end
        end
    end

    // Moved data: register values, immediate, or the first read
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            data_hi <= '0;
            data_lo <= '0;
        end
        else if (launch)
        begin
            if (cur.form == msd_pkg::MSD_FORM_DOUBLE)
            begin
                data_hi <= reg_rdata[2*DATA_W-1:DATA_W];
                data_lo <= reg_rdata[DATA_W-1:0];
            end
            else if (cur.is_imm)
                data_lo <= ext_word;
            else
                data_lo <= reg_value;
        end
        else if (state == msd_pkg::MSD_ST_READ && mem_ack)
        begin
            if (is_double)
                data_hi <= mem_rdata;
            else
                data_lo <= mem_rdata;
        end
    end

    // Flags change only when the status word itself is written
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            status_word <= `MSD_STATUS_RST;
        else if (load_status)
        begin
            status_word.cond              <= mem_rdata[`MSD_CC_MSB:`MSD_CC_LSB]; // RULE1
            status_word.exception_status  <= mem_rdata[`MSD_EXC_MSB:`MSD_EXC_LSB]; // RULE2
            status_word.trap_enable_flags <= mem_rdata[`MSD_TRAP_MSB:`MSD_TRAP_LSB]; // RULE3
        end
        else
            status_word <= status_word; // RULE4
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            done    <= 1'b0;
            illegal <= 1'b0;
        end
        else
        begin
            done    <= finish;
            // Bad opcodes are consumed without any effect
            illegal <= instr_ready && instr_valid && !dec.legal;
        end
    end

endmodule

// >>> verif/msd_short_move_monitor.sv
// Purpose: Port checks for the absolute short move decoder
// Assumes: Bound to every msd_short_move instance
// Notes:   Status checks fire only when a status field changes
`timescale 1ns/10ps
module msd_short_move_monitor
#(
    parameter int DATA_W = 32
)
(
    // Clock and reset
    input wire logic                 clock,
    input wire logic                 sys_rst,
    // Handshake and memory
    input wire logic                 instr_ready,
    input wire logic                 mem_req,
    input wire logic                 mem_we,
    input wire logic                 mem_ack,
    input wire logic [DATA_W-1:0]    mem_addr,
    input wire logic [DATA_W-1:0]    mem_rdata,
    // Results
    input wire logic                 reg_wr,
    input wire logic [6:0]           reg_wr_code,
    input wire msd_pkg::msd_status_t status_word,
    input wire logic                 done,
    input wire logic                 illegal,
    input wire logic [1:0]           instr_words
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_status_cond: assert property (!$stable(status_word.cond) |->
        $past(mem_req && mem_ack && !mem_we) && status_word.cond == $past(mem_rdata[7:0]))
        else $error("condition flags not loaded from source bits");
    a_status_exc: assert property (!$stable(status_word.exception_status) |->
        status_word.exception_status == $past(mem_rdata[15:8]))
        else $error("exception bits not loaded from source bits");
    a_status_trap: assert property (!$stable(status_word.trap_enable_flags) |->
        status_word.trap_enable_flags == $past(mem_rdata[20:16]))
        else $error("trap enables not loaded from source bits");
    a_req_hold: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request changed while stalled");
    a_no_status_wr: assert property (reg_wr |-> reg_wr_code != 7'h79)
        else $error("status code seen on register write");
    a_done_cause: assert property (done |-> $past(mem_req && mem_ack) && !$past(done))
        else $error("done without a completed access");
    a_busy_refuse: assert property (mem_req |-> !instr_ready)
        else $error("opcode accepted while busy");
    a_words_range: assert property (instr_words == 2'h1 || instr_words == 2'h2)
        else $error("instruction length out of range");
    a_illegal_quiet: assert property (illegal |-> !mem_req && !reg_wr)
        else $error("illegal opcode caused an access");
endmodule

bind msd_short_move msd_short_move_monitor #(.DATA_W(DATA_W)) msd_short_move_monitor_inst
    (.clock, .sys_rst, .instr_ready, .mem_req, .mem_we, .mem_ack, .mem_addr, .mem_rdata,
     .reg_wr, .reg_wr_code, .status_word, .done, .illegal, .instr_words);

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the absolute short move decoder
// Assumes: Bench plays memory, register file and address unit
// Notes:   Memory acks at once except where a test stalls it
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module tb_top;
    logic        clock = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, ext_valid = 1'b0;
    logic        mem_ack = 1'b1;
    logic [31:0] instr_word = 32'h0, ext_word = 32'h0, mem_rdata = 32'h0;
    logic [31:0] agu_addr = 32'h0badf00d;
    logic [63:0] reg_rdata = 64'hffffffff1234abcd;
    logic        instr_ready, ext_ready, agu_req, agu_disp, mem_req, mem_we;
    logic        reg_wr, reg_wr_double, done, illegal;
    logic [5:0]  agu_mode_reg;
    logic [31:0] agu_ext, mem_addr, mem_wdata;
    logic [6:0]  reg_rd_code, reg_wr_code;
    logic [63:0] reg_wdata;
    logic [1:0]  instr_words;
    msd_pkg::msd_space_t  mem_space;
    msd_pkg::msd_status_t status_word;
    int          bad_count = 0, checks_done = 0, cycles = 0;

    msd_short_move #(.DATA_W(32)) msd_short_move_inst
        (.clock, .sys_rst, .instr_valid, .instr_word, .instr_ready, .ext_valid, .ext_word,
         .ext_ready, .agu_req, .agu_mode_reg, .agu_disp, .agu_ext, .agu_addr, .mem_req,
         .mem_we, .mem_space, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .reg_rd_code,
         .reg_rdata, .reg_wr, .reg_wr_double, .reg_wr_code, .reg_wdata, .status_word,
         .done, .illegal, .instr_words);

    always #25 clock = ~clock;

    // Hang guard; all tests need well under a hundred cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            bad_count++;
            stop_test();
        end
    end

    function automatic logic [31:0] op(input logic [6:0] c, input logic s, w, input logic [6:0] a);
        return {12'h007, c, 1'b0, 2'b00, s, w, 1'b0, a};
    endfunction

    task automatic step;
        @(posedge clock);
        #1;
    endtask

    task automatic issue(input logic [31:0] w);
        instr_valid <= 1'b1;
        instr_word  <= w;
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic t_single_write;
        issue(op(7'h08, 1'b1, 1'b1, 7'h7f));
        `CHK("write req", 2'b11, {mem_req, mem_we})
        `CHK("space", msd_pkg::MSD_SPACE_Y, mem_space)
        `CHK("short addr", 32'h0000007f, mem_addr)
        `CHK("wdata", 32'h1234abcd, mem_wdata)
        step();
        `CHK("done", 1'b1, done)
        `CHK("words", 2'h1, instr_words)
        $display("test single_write ended");
    endtask

    // Stalled read into the status word; the stall must not load early
    task automatic t_status_load;
        mem_ack   <= 1'b0;
        mem_rdata <= 32'hffe5a5c3;
        issue(op(7'h79, 1'b0, 1'b0, 7'h05));
        `CHK("read addr", 32'h00000005, mem_addr)
        step();
        `CHK("stalled status", 21'h0, status_word)
        mem_ack <= 1'b1;
        step();
        `CHK("done", 1'b1, done)
        `CHK("cond", 8'hc3, status_word.cond)
        `CHK("exc", 8'ha5, status_word.exception_status)
        `CHK("trap", 5'h05, status_word.trap_enable_flags)
        $display("test status_load ended");
    endtask

    task automatic t_other_dest;
        mem_rdata <= 32'h00f00000;
        issue(op(7'h26, 1'b1, 1'b0, 7'h40));
        `CHK("space", msd_pkg::MSD_SPACE_Y, mem_space)
        `CHK("reg wr", 8'ha6, {reg_wr, reg_wr_code})
        `CHK("reg data", 64'h0000000000f00000, reg_wdata)
        step();
        `CHK("status kept", 21'h05a5c3, status_word)
        $display("test other_dest ended");
    endtask

    // Absolute ea to short location; ext word offered early must wait for the extension cycle
    task automatic t_mem_mem;
        ext_valid <= 1'b1;
        ext_word  <= 32'hdeadbeef;
        mem_rdata <= 32'h600dcafe;
        issue({12'h007, 6'h30, 2'b11, 4'b1001, 1'b0, 7'h11});
        `CHK("ext ready", 3'b100, {ext_ready, mem_req, agu_req})
        `CHK("words", 2'h2, instr_words)
        step();
        ext_valid <= 1'b0;
        `CHK("ea read", {1'b1, 1'b0, 32'hdeadbeef}, {mem_req, mem_we, mem_addr})
        step();
        `CHK("short write", {1'b1, 32'h00000011, 32'h600dcafe}, {mem_we, mem_addr, mem_wdata})
        step();
        `CHK("done", 1'b1, done)
        $display("test mem_mem ended");
    endtask

    task automatic t_illegal;
        logic [31:0] bad [3];
        bad = '{op(7'h08, 1'b0, 1'b1, 7'h7f) | 32'h80,
                {12'h007, 6'h34, 2'b11, 4'b0101, 1'b0, 7'h01},
                {12'h017, 7'h08, 1'b0, 4'b0001, 1'b0, 7'h01}};
        foreach (bad[i])
        begin
            issue(bad[i]);
            `CHK("illegal", 2'b10, {illegal, mem_req})
        end
        `CHK("status kept", 21'h05a5c3, status_word)
        $display("test illegal ended");
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        step();
        t_single_write();
        t_status_load();
        t_other_dest();
        t_mem_mem();
        t_illegal();
        stop_test();
    end
endmodule
